/* rtl/servo_homing_sequencer.sv */
// homing sequencer for methods 1 to 7 of a servo axis
`timescale 1ns/10ps
module servo_homing_sequencer
    import homing_pkg::*;
(
    input  wire logic                sys_clk_i,
    input  wire logic                rstn_i,
    input  wire logic                start_i,
    input  wire logic [METHOD_W-1:0] homing_method_select_i,
    input  wire sw_t                 switches_i,
    input  wire logic [POS_W-1:0]    position_i,
    output motion_cmd_t              motion_o,
    output logic                     busy_o,
    output logic                     done_o,
    output logic                     homing_method_error_o,
    output logic [POS_W-1:0]         origin_pos_o
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic method_ok(input logic [METHOD_W-1:0] m);
        method_ok = (m >= METHOD_MIN) && (m <= METHOD_MAX);
    endfunction

    // reference signal of each method
    function automatic logic pick(input logic [METHOD_W-1:0] m, input sw_t s);
        if (m == M_NEG_LIM)
            pick = s.neg;
        else if (m == M_POS_LIM)
            pick = s.pos;
        else
            pick = s.org;
    endfunction

    // direction of the fast seek; the slow start runs the other way
    function automatic logic seek_pos(input logic [METHOD_W-1:0] m);
        seek_pos = (m == M_POS_LIM) || (m == M_ORG_POS) || (m == M_ORG_POS_S)
                   || (m == M_ORG_PLIM);
    endfunction

    function automatic logic keeps_dir(input logic [METHOD_W-1:0] m);
        keeps_dir = (m == M_ORG_POS_S) || (m == M_ORG_NEG_S);
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    sw_t sw_lvl;
    sw_t sw_rise;
    sw_t sw_fall;

    switch_edge_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .raw_i     (switches_i),
        .level_o   (sw_lvl),
        .rise_o    (sw_rise),
        .fall_o    (sw_fall)
    );

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    home_state_t          state;
    home_state_t          next_state;
    motion_cmd_t          cmd;
    motion_cmd_t          next_cmd;
    logic [METHOD_W-1:0]  method;
    logic [METHOD_W-1:0]  next_method;
    logic                 err;
    logic                 next_err;
    logic                 done;
    logic                 next_done;
    logic [POS_W-1:0]     origin;
    logic [POS_W-1:0]     next_origin;
    logic                 sel_rise;
    logic                 sel_fall;

    assign sel_rise = pick(method, sw_rise);
    assign sel_fall = pick(method, sw_fall);

    always_comb
    begin
        next_state  = state;
        next_cmd    = cmd;
        next_method = method;
        next_err    = err;
        next_done   = 1'b0;
        next_origin = origin;
        next_cmd.decel = 1'b0;
        case (state)
            S_IDLE:
            begin
                if (start_i)
                begin
                    next_method = homing_method_select_i;
                    if (!method_ok(homing_method_select_i))
                    begin
                        next_err = 1'b1;
                    end
                    else
                    begin
                        next_err     = 1'b0;
                        next_cmd.run = 1'b1;
                        if (!pick(homing_method_select_i, sw_lvl))
                        begin
                            next_state          = S_FAST_SEEK;
                            next_cmd.high_speed = 1'b1;
                            next_cmd.dir_pos    = seek_pos(homing_method_select_i);
                        end
                        else
                        begin
                            next_cmd.high_speed = 1'b0;
                            next_cmd.dir_pos    = ~seek_pos(homing_method_select_i);
                            next_state = keeps_dir(homing_method_select_i) ? S_SLOW_REV
                                                                           : S_SLOW_OUT;
                        end
                    end
                end
            end
            S_FAST_SEEK:
            begin
                if ((method == M_ORG_PLIM) && sw_rise.pos)
                begin
                    next_state       = S_FAST_BACK;
                    next_cmd.dir_pos = 1'b0;
                    next_cmd.decel   = 1'b1;
                end
                else if (sel_rise)
                begin
                    next_cmd.high_speed = 1'b0;
                    next_cmd.decel      = 1'b1;
                    if (keeps_dir(method))
                    begin
                        next_state = S_ARM;
                    end
                    else
                    begin
                        next_state       = S_SLOW_OUT;
                        next_cmd.dir_pos = ~cmd.dir_pos;
                    end
                end
            end
            S_FAST_BACK:
            begin
                if (sw_rise.org)
                begin
                    next_state          = S_SLOW_OUT;
                    next_cmd.high_speed = 1'b0;
                    next_cmd.decel      = 1'b1;
                end
            end
            S_SLOW_OUT:
            begin
                if (sel_fall)
                begin
                    next_state = S_ARM;
                end
            end
            S_SLOW_REV:
            begin
                if (sel_fall)
                begin
                    next_state       = S_SLOW_IN;
                    next_cmd.dir_pos = ~cmd.dir_pos;
                    next_cmd.decel   = 1'b1;
                end
            end
            S_SLOW_IN:
            begin
                if (sel_rise)
                begin
                    next_state = S_ARM;
                end
            end
            S_ARM:
            begin
                if (sw_rise.idx)
                begin
                    next_state     = S_IDLE;
                    next_cmd.run   = 1'b0;
                    next_cmd.decel = 1'b1;
                    next_done      = 1'b1;
                    next_origin    = position_i;
                end
            end
            default:
            begin
                next_state = S_IDLE;
                next_cmd   = CMD_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state  <= S_IDLE;
            cmd    <= CMD_RST;
            method <= RST_METHOD;
            err    <= 1'b0;
            done   <= 1'b0;
            origin <= RST_ORIGIN;
        end
        else
        begin
            state  <= next_state;
            cmd    <= next_cmd;
            method <= next_method;
            err    <= next_err;
            done   <= next_done;
            origin <= next_origin;
        end
    end

    assign motion_o              = cmd;
    assign busy_o                = (state != S_IDLE);
    assign done_o                = done;
    assign homing_method_error_o = err;
    assign origin_pos_o          = origin;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    logic idle_start;
    assign idle_start = start_i && (state == S_IDLE);

    a_bad_method: assert property (
        idle_start && !method_ok(homing_method_select_i)
        |=> homing_method_error_o && !busy_o && !motion_o.run)
        else $error("bad method did not raise the error");
    a_m1_fast: assert property (
        idle_start && (homing_method_select_i == M_NEG_LIM) && !sw_lvl.neg
        |=> motion_o.run && !motion_o.dir_pos && motion_o.high_speed)
        else $error("method 1 fast seek wrong");
    a_m1_slow: assert property (
        idle_start && (homing_method_select_i == M_NEG_LIM) && sw_lvl.neg
        |=> motion_o.run && motion_o.dir_pos && !motion_o.high_speed)
        else $error("method 1 slow start wrong");
    a_m2_fast: assert property (
        idle_start && (homing_method_select_i == M_POS_LIM) && !sw_lvl.pos
        |=> motion_o.dir_pos && motion_o.high_speed)
        else $error("method 2 fast seek wrong");
    a_m2_slow: assert property (
        idle_start && (homing_method_select_i == M_POS_LIM) && sw_lvl.pos
        |=> !motion_o.dir_pos && !motion_o.high_speed)
        else $error("method 2 slow start wrong");
    a_seek_reverse: assert property (
        state == S_FAST_SEEK && sel_rise && !keeps_dir(method)
        && !((method == M_ORG_PLIM) && sw_rise.pos)
        |=> motion_o.decel && !motion_o.high_speed && (motion_o.dir_pos != $past(cmd.dir_pos)))
        else $error("seek did not reverse at slow speed");
    a_seek_keep_dir: assert property (
        state == S_FAST_SEEK && sel_rise && keeps_dir(method)
        |=> $stable(motion_o.dir_pos) && !motion_o.high_speed && state == S_ARM)
        else $error("methods 4 and 6 must keep direction");
    a_m7_limit: assert property (
        state == S_FAST_SEEK && method == M_ORG_PLIM && sw_rise.pos
        |=> !motion_o.dir_pos && motion_o.high_speed ##0 state == S_FAST_BACK)
        else $error("method 7 limit turn wrong");
    a_done_latch: assert property (
        state == S_ARM && sw_rise.idx
        |=> done_o && !motion_o.run && origin_pos_o == $past(position_i) ##1 !done_o)
        else $error("origin not latched on index");

    c_m1_done: cover property (idle_start && homing_method_select_i == M_NEG_LIM ##[1:1000] done_o);
    c_m7_back: cover property (state == S_FAST_BACK ##[1:1000] done_o);
    c_rev: cover property (state == S_SLOW_REV ##[1:200] state == S_SLOW_IN);
    c_err: cover property ($rose(homing_method_error_o));

endmodule

/* rtl/homing_pkg.sv */
// constants and types for the servo homing sequencer
// Behaviour
// - method 1, negative limit off: fast negative, on rise slow positive, index after fall
// - method 1, negative limit on: slow positive, first index after its fall
// - method 2, positive limit off: fast positive, on rise slow negative, index after fall
// - method 2, positive limit on: slow negative, first index after its fall
// - methods 3/7, origin off: fast positive, on rise slow negative, index after fall
// - methods 3/7, origin on: slow negative, first index after origin fall
// - method 4, origin off: fast positive, on rise slow same way, next index
// - method 4, origin on: slow negative, on fall slow positive, index after rise
// - method 5, origin off: fast negative, on rise slow positive, index after fall
// - method 5, origin on: slow positive, first index after origin fall
// - method 6, origin off: fast negative, on rise slow same way, next index
// - method 6, origin on: slow positive, on fall slow negative, index after rise
// - method 7, positive limit rise while seeking: fast negative, slow on origin rise
// - start in idle with unsupported method code raises the method error flag; start while busy is ignored
package homing_pkg;

    localparam int          SW_W        = 4;
    localparam int          METHOD_W    = 8;
    localparam int          POS_W       = 32;
    localparam logic [7:0]  METHOD_MIN  = 8'h01;
    localparam logic [7:0]  METHOD_MAX  = 8'h07;
    localparam logic [7:0]  M_NEG_LIM   = 8'h01;
    localparam logic [7:0]  M_POS_LIM   = 8'h02;
    localparam logic [7:0]  M_ORG_POS   = 8'h03;
    localparam logic [7:0]  M_ORG_POS_S = 8'h04;
    localparam logic [7:0]  M_ORG_NEG   = 8'h05;
    localparam logic [7:0]  M_ORG_NEG_S = 8'h06;
    localparam logic [7:0]  M_ORG_PLIM  = 8'h07;
    localparam logic [7:0]  RST_METHOD  = 8'h00;
    localparam logic [31:0] RST_ORIGIN  = 32'h0000_0000;

    // switch and encoder inputs, bit 0 is the negative limit
    typedef struct packed {
        logic idx;
        logic org;
        logic pos;
        logic neg;
    } sw_t;

    // motion command towards the speed loop
    typedef struct packed {
        logic run;
        logic dir_pos;
        logic high_speed;
        logic decel;
    } motion_cmd_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FAST_SEEK,
        S_FAST_BACK,
        S_SLOW_OUT,
        S_SLOW_REV,
        S_SLOW_IN,
        S_ARM
    } home_state_t;

    localparam motion_cmd_t CMD_RST = '{run: 1'b0, dir_pos: 1'b0, high_speed: 1'b0, decel: 1'b0};

endpackage

/* rtl/switch_edge_sync.sv */
// two-stage synchroniser and edge detector for switch and index pins
`timescale 1ns/10ps
module switch_edge_sync
    import homing_pkg::*;
(
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    input  wire sw_t  raw_i,
    output sw_t       level_o,
    output sw_t       rise_o,
    output sw_t       fall_o
);

    logic [SW_W-1:0] meta;
    logic [SW_W-1:0] stab;
    logic [SW_W-1:0] prev;

    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta <= '0;
            stab <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= raw_i;
            stab <= meta;
            prev <= stab;
        end
    end

    assign level_o = stab;
    assign rise_o  = stab & ~prev;
    assign fall_o  = ~stab & prev;

endmodule

/* tb/axis_model.sv */
// axis model: moves on motion commands, drives limits, origin switch and index
`timescale 1ns/10ps
module axis_model
    import homing_pkg::*;
#(
    parameter int NEG_LIM   = -3000,
    parameter int POS_LIM   = 3000,
    parameter int ORG_LO    = 1000,
    parameter int ORG_HI    = 1200,
    parameter int FAST_STEP = 4,
    parameter int IDX_MASK  = 63
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             load_i,
    input  wire logic [POS_W-1:0] load_pos_i,
    input  wire motion_cmd_t      motion_i,
    output sw_t                   switches_o,
    output logic [POS_W-1:0]      position_o
);
    int pos;
    int step;

    // --------------------------------------------------------------
    // axis travel
    // --------------------------------------------------------------
    always_comb
    begin
        step = motion_i.high_speed ? FAST_STEP : 1;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (load_i)
            pos <= $signed(load_pos_i);
        else if (motion_i.run)
            pos <= motion_i.dir_pos ? pos + step : pos - step;
    end

    // --------------------------------------------------------------
    // switches and encoder, index once per pitch
    // --------------------------------------------------------------
    always_comb
    begin
        switches_o.neg = (pos <= NEG_LIM);
        switches_o.pos = (pos >= POS_LIM);
        switches_o.org = (pos >= ORG_LO) && (pos <= ORG_HI);
        switches_o.idx = ((pos & IDX_MASK) == 0);
        position_o     = pos[POS_W-1:0];
    end
endmodule

/* tb/tb.sv */
// self-checking testbench for the homing sequencer
`timescale 1ns/10ps
`define CHECK(got, exp, msg) \
    begin checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch t=%0t %s", $time, msg); end end
module tb
    import homing_pkg::*;
    ;
    localparam logic [7:0] BAD [6] = '{8'h00, 8'h08, 8'h0F, 8'h10, 8'h1F, 8'h20};

    logic             sys_clk  = 1'b0;
    logic             rstn     = 1'b0;
    logic             start    = 1'b0;
    logic [7:0]       method   = 8'h00;
    logic             load     = 1'b0;
    logic [POS_W-1:0] load_pos = 32'h0000_0000;
    sw_t              switches;
    logic [POS_W-1:0] position;
    motion_cmd_t      motion;
    logic             busy;
    logic             done;
    logic             method_err;
    logic [POS_W-1:0] origin;
    int               mismatches = 0;
    int               checks     = 0;

    always #12.5 sys_clk = ~sys_clk;

    servo_homing_sequencer u_dut (
        .sys_clk_i              (sys_clk),
        .rstn_i                 (rstn),
        .start_i                (start),
        .homing_method_select_i (method),
        .switches_i             (switches),
        .position_i             (position),
        .motion_o               (motion),
        .busy_o                 (busy),
        .done_o                 (done),
        .homing_method_error_o  (method_err),
        .origin_pos_o           (origin)
    );

    axis_model u_axis (
        .sys_clk_i  (sys_clk),
        .load_i     (load),
        .load_pos_i (load_pos),
        .motion_i   (motion),
        .switches_o (switches),
        .position_o (position)
    );

    // --------------------------------------------------------------
    // shared steps
    // --------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic begin_home(input logic [7:0] code, input int start_pos,
                              input logic dir, input logic fast);
        @(posedge sys_clk);
        load     <= 1'b1;
        load_pos <= 32'(start_pos);
        @(posedge sys_clk);
        load <= 1'b0;
        repeat (5) @(posedge sys_clk);
        start  <= 1'b1;
        method <= code;
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        `CHECK(motion.run, 1'b1, "no motion after start")
        `CHECK(motion.dir_pos, dir, "first direction")
        `CHECK(motion.high_speed, fast, "first speed")
        `CHECK(busy, 1'b1, "not busy after start")
    endtask

    task automatic end_home(input int org);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 3000)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHECK(done, 1'b1, "no completion")
        `CHECK(motion.run, 1'b0, "motion not stopped")
        `CHECK(motion.decel, 1'b1, "no stop ramp")
        `CHECK(origin, 32'(org), "origin position")
        `CHECK(busy, 1'b0, "busy after completion")
        @(posedge sys_clk);
        #1;
        `CHECK(done, 1'b0, "completion not a pulse")
    endtask

    task automatic home(input logic [7:0] code, input int start_pos,
                        input logic dir, input logic fast, input int org);
        begin_home(code, start_pos, dir, fast);
        end_home(org);
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_bad_codes;
        foreach (BAD[i])
        begin
            @(posedge sys_clk);
            start  <= 1'b1;
            method <= BAD[i];
            @(posedge sys_clk);
            start <= 1'b0;
            #1;
            `CHECK(method_err, 1'b1, "bad code not flagged")
            `CHECK(busy, 1'b0, "bad code started homing")
        end
        begin_home(M_NEG_LIM, -3100, 1'b1, 1'b0);
        `CHECK(method_err, 1'b0, "flag not cleared")
        end_home(-2942);
    endtask

    task automatic t_busy_refused;
        begin_home(M_POS_LIM, 0, 1'b1, 1'b1);
        repeat (20) @(posedge sys_clk);
        start  <= 1'b1;
        method <= 8'h0F;
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        `CHECK(method_err, 1'b0, "start taken while busy")
        `CHECK(motion.high_speed, 1'b1, "seek disturbed")
        end_home(2942);
    endtask

    // origin is two slow steps past the index, the pin sync delay
    task automatic t_methods;
        home(M_NEG_LIM, 0, 1'b0, 1'b1, -2942);
        home(M_NEG_LIM, -3100, 1'b1, 1'b0, -2942);
        home(M_POS_LIM, 0, 1'b1, 1'b1, 2942);
        home(M_POS_LIM, 3100, 1'b0, 1'b0, 2942);
        home(M_ORG_POS, 0, 1'b1, 1'b1, 958);
        home(M_ORG_PLIM, 0, 1'b1, 1'b1, 958);
        home(M_ORG_POS, 1100, 1'b0, 1'b0, 958);
        home(M_ORG_PLIM, 1100, 1'b0, 1'b0, 958);
        home(M_ORG_POS_S, 0, 1'b1, 1'b1, 1026);
        home(M_ORG_POS_S, 1100, 1'b0, 1'b0, 1026);
        home(M_ORG_NEG, 2000, 1'b0, 1'b1, 1218);
        home(M_ORG_NEG, 1100, 1'b1, 1'b0, 1218);
        home(M_ORG_NEG_S, 2000, 1'b0, 1'b1, 1150);
        home(M_ORG_NEG_S, 1100, 1'b1, 1'b0, 1150);
        home(M_ORG_PLIM, 1300, 1'b1, 1'b1, 958);
    endtask

    // --------------------------------------------------------------
    // main sequence and watchdog
    // --------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_bad_codes();
        t_busy_refused();
        t_methods();
        finish_test();
    end

    initial
    begin
        #(25ns * 40000);
        mismatches++;
        finish_test();
    end
endmodule
